// ### common/dsphy_regs.vh
// Constants for the data-strobe PHY transmit/receive data path.
// Assumes the includer works in the reference-clock domain.
`ifndef DSPHY_REGS_VH
`define DSPHY_REGS_VH

// ----------------------------------------------------------------
// Clock plan
// ----------------------------------------------------------------
`define DSPHY_XTAL_KHZ      24576
`define DSPHY_REF_KHZ       393216
`define DSPHY_LINK_KHZ      49152
`define DSPHY_LINK_DIV      (`DSPHY_REF_KHZ / `DSPHY_LINK_KHZ)
`define DSPHY_PLL_MULT      (`DSPHY_REF_KHZ / `DSPHY_XTAL_KHZ)

// ----------------------------------------------------------------
// Speed codes, bits per link word, bit period mask
// ----------------------------------------------------------------
`define DSPHY_SPD_S100      2'h0
`define DSPHY_SPD_S200      2'h1
`define DSPHY_SPD_S400      2'h2
`define DSPHY_W_S100        4'h2
`define DSPHY_W_S200        4'h4
`define DSPHY_W_S400        4'h8
`define DSPHY_PER_S100      3'h3
`define DSPHY_PER_S200      3'h1
`define DSPHY_PER_S400      3'h0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DSPHY_RST_BYTE      8'h00
`define DSPHY_RST_BIT       1'h0
`define DSPHY_RST_OE_B      1'h1
// Divider rests on its last count, so a restart opens a whole link period
`define DSPHY_RST_CNT       3'h7

`endif

// ### rtl/dsphy_datapath.v
// Data-strobe PHY data path: link word latch, serializer, DS encoder,
// DS decoder, resynchronizer, repeater and link-side isolation coding.
// Assumes clock is the PLL reference (one cable bit time at S400) and
// that arbitration logic on the same clock supplies rx_active/rx_port.
//
// Behaviour
// RQ1 - Drive a continuous link clock; all link data is synchronous to it.
// RQ2 - Reference comes from crystal via PLL; divided down for bit timing.
// RQ3 - Power-down stops PLL and everything except B-pair bias detectors.
// RQ4 - Disabled, suspended or disconnected ports have transmitter, receiver off.
// RQ5 - Isolation select high: link-side outputs are plain levels.
// RQ6 - Isolation select low: link-side outputs are edge coded for barriers.
// RQ7 - Link presents transmit data on 2, 4 or 8 lines by speed.
// RQ8 - Transmit data is latched on the link clock.
// RQ9 - Latched bits are serialized and DS encoded at S100/S200/S400.
// RQ10 - Encoded data drives TPB, encoded strobe drives TPA on active ports.
// RQ11 - Receiving port has both transmitters off and receivers on.
// RQ12 - Received data comes from TPA, received strobe from TPB.
// RQ13 - Decoder recovers bit clock and serial bits from data and strobe.
// RQ14 - Recovered data is resynchronized into the link clock domain.
// RQ15 - Receive words go to the link at 2, 4 or 8 bits by speed.
// RQ16 - Received bits are repeated on every other active connected port.
// RQ17 - Data lines are two-way; each side drives only its own direction.
// RQ18 - One of data or strobe changes per bit; clock is data xor strobe.
// RQ19 - Narrow speeds use lowest lines; unused lines are ignored on transmit.
module dsphy_datapath
#(
    parameter NPORT = 3
)
(
    // Clock and reset
    input  wire             clock,
    input  wire             rst_b,
    // Pins: power down and isolation select (low enables coding)
    input  wire             power_down_input,
    input  wire             iso_select_b,
    // Clocks and PLL control
    output reg              link_clock_out,
    output reg              pll_run,
    // Link data lines, split into in, out and active-low enable
    input  wire [7:0]       link_data_lines_in,
    output reg  [7:0]       link_data_lines_out,
    output reg  [7:0]       link_data_lines_oe_b,
    // Link transmit control, same clock domain
    input  wire             tx_valid,
    input  wire [1:0]       tx_speed,
    // Link receive status
    output reg              rx_valid,
    output reg  [1:0]       rx_speed_out,
    // Arbitration inputs, same clock domain
    input  wire             rx_active,
    input  wire [1:0]       rx_port,
    input  wire [1:0]       rx_speed,
    // Port state
    input  wire [NPORT-1:0] port_connected,
    input  wire [NPORT-1:0] port_disabled,
    input  wire [NPORT-1:0] port_suspended,
    // Cable receive comparators
    input  wire [NPORT-1:0] tpa_rx,
    input  wire [NPORT-1:0] tpb_rx,
    // Cable drivers (enables active low), then active-high receiver and bias detector enables
    output reg  [NPORT-1:0] tpa_tx,
    output reg  [NPORT-1:0] tpa_tx_oe_b,
    output reg  [NPORT-1:0] tpb_tx,
    output reg  [NPORT-1:0] tpb_tx_oe_b,
    output reg  [NPORT-1:0] rx_enable,
    output reg  [NPORT-1:0] bias_detect_en
);

`include "dsphy_regs.vh"

    localparam SW = 2 + 2 * NPORT;
    localparam integer LINK_LAST_I = `DSPHY_LINK_DIV - 1;
    localparam integer LINK_HALF_I = `DSPHY_LINK_DIV / 2;
    localparam [2:0]   LINK_LAST   = LINK_LAST_I[2:0];
    localparam [2:0]   LINK_HALF   = LINK_HALF_I[2:0];
    // Idle pattern of the pin stages, so iso select cannot blink at reset
    localparam [SW-1:0] SYNC_IDLE  = {1'b0, 1'b1, {(2*NPORT){1'b0}}};

    // ------------------------------------------------------------
    // Speed helpers
    // ------------------------------------------------------------
    function [3:0] spd_width;
        input [1:0] spd;
        begin
            case (spd)
                `DSPHY_SPD_S100: spd_width = `DSPHY_W_S100;
                `DSPHY_SPD_S200: spd_width = `DSPHY_W_S200;
                default:         spd_width = `DSPHY_W_S400;
            endcase
        end
    endfunction

    function [2:0] spd_per;
        input [1:0] spd;
        begin
            case (spd)
                `DSPHY_SPD_S100: spd_per = `DSPHY_PER_S100;
                `DSPHY_SPD_S200: spd_per = `DSPHY_PER_S200;
                default:         spd_per = `DSPHY_PER_S400;
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // Pin synchronizers
    // ------------------------------------------------------------
    reg  [SW-1:0]    s1_reg;
    reg  [SW-1:0]    s2_reg;
    reg  [SW-1:0]    s3_reg;
    reg  [SW-1:0]    filt_reg;
    wire [SW-1:0]    agree;
    wire             pd;
    wire             iso_hi;
    wire [NPORT-1:0] tpa_f;
    wire [NPORT-1:0] tpb_f;

    assign agree  = ~(s2_reg ^ s3_reg);
    assign pd     = filt_reg[SW-1];
    assign iso_hi = filt_reg[SW-2];
    assign tpa_f  = filt_reg[2*NPORT-1:NPORT];
    assign tpb_f  = filt_reg[NPORT-1:0];

    // Three stages; a level counts only once stages two and three agree
    always @(posedge clock)
    begin
        if (!rst_b)
        begin
            s1_reg   <= SYNC_IDLE;
            s2_reg   <= SYNC_IDLE;
            s3_reg   <= SYNC_IDLE;
            filt_reg <= SYNC_IDLE;
        end
        else
        begin
            s1_reg   <= {power_down_input, iso_select_b, tpa_rx, tpb_rx};
            s2_reg   <= s1_reg;
            s3_reg   <= s2_reg;
            filt_reg <= (s3_reg & agree) | (filt_reg & ~agree);
        end
    end

    // ------------------------------------------------------------
    // Link clock divider
    // ------------------------------------------------------------
    reg  [2:0] div_cnt_reg;
    wire       link_tick;

    assign link_tick = (div_cnt_reg == LINK_LAST);

    // Reference divided down; frozen in power down with the PLL
    always @(posedge clock)
    begin
        if (!rst_b)
        begin
            div_cnt_reg    <= `DSPHY_RST_CNT;
            link_clock_out <= `DSPHY_RST_BIT;
            pll_run        <= `DSPHY_RST_BIT;
        end
        else
        begin
            pll_run <= ~pd;                              // [RQ2] [RQ3]
            if (pd)
            begin
                div_cnt_reg    <= `DSPHY_RST_CNT;        // [RQ3]
                link_clock_out <= `DSPHY_RST_BIT;
            end
            else
            begin
                div_cnt_reg    <= div_cnt_reg + 3'h1;    // [RQ2]
                link_clock_out <= (div_cnt_reg + 3'h1) < LINK_HALF; // [RQ1]
            end
        end
    end

    // ------------------------------------------------------------
    // Transmit latch and serializer
    // ------------------------------------------------------------
    reg  [7:0]       tx_shift_reg;
    reg  [1:0]       tx_spd_reg;
    reg              tx_on_reg;
    wire [7:0]       tx_mask;
    wire             tx_bit_evt;
    wire [NPORT-1:0] port_ok;

    // Lines above the speed's width are don't-care from the link
    assign tx_mask    = (8'h01 << spd_width(tx_speed)) - 8'h01; // [RQ19]
    assign tx_bit_evt = tx_on_reg &
        ((div_cnt_reg & spd_per(tx_spd_reg)) == spd_per(tx_spd_reg));
    assign port_ok    = port_connected & ~port_disabled & ~port_suspended;

    // Word loads on the same link edge that sends out the last bit of the word before it
    always @(posedge clock)
    begin
        if (!rst_b || pd)
        begin
            tx_shift_reg <= `DSPHY_RST_BYTE;
            tx_spd_reg   <= `DSPHY_SPD_S100;
            tx_on_reg    <= `DSPHY_RST_BIT;
        end
        else if (link_tick)
        begin
            tx_shift_reg <= link_data_lines_in & tx_mask;  // [RQ7] [RQ8]
            tx_spd_reg   <= tx_speed;
            tx_on_reg    <= tx_valid & ~rx_active;
        end
        else if (tx_bit_evt)
            tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};     // [RQ9]
    end

    // ------------------------------------------------------------
    // Receive decoder
    // ------------------------------------------------------------
    reg        rx_x_reg;
    reg  [7:0] rx_shift_reg;
    reg  [3:0] rx_cnt_reg;
    reg  [7:0] rx_hold_reg;
    reg        rx_full_reg;
    wire       rx_d;
    wire       rx_s;
    wire       rx_evt;
    wire       rx_done;
    reg  [7:0] rx_word;

    assign rx_d    = tpa_f[rx_port];                        // [RQ12]
    assign rx_s    = tpb_f[rx_port];
    assign rx_evt  = rx_active & ~pd & ((rx_d ^ rx_s) != rx_x_reg); // [RQ13]
    assign rx_done = rx_evt & ((rx_cnt_reg + 4'h1) == spd_width(rx_speed));

    // Recovered bit dropped into its slot, first bit lowest
    always @*
    begin
        rx_word = rx_shift_reg;
        rx_word[rx_cnt_reg[2:0]] = rx_d;
    end

    // Bit clock is each change of data xor strobe
    always @(posedge clock)
    begin
        if (!rst_b || pd || !rx_active)
        begin
            rx_x_reg     <= rx_d ^ rx_s;
            rx_shift_reg <= `DSPHY_RST_BYTE;
            rx_cnt_reg   <= 4'h0;
        end
        else if (rx_evt)
        begin
            rx_x_reg <= rx_d ^ rx_s;                        // [RQ18]
            if (rx_done)
            begin
                rx_shift_reg <= `DSPHY_RST_BYTE;
                rx_cnt_reg   <= 4'h0;
            end
            else
            begin
                rx_shift_reg <= rx_word;
                rx_cnt_reg   <= rx_cnt_reg + 4'h1;
            end
        end
    end

    // Holding word crosses to the link edge; a new word beats the drain
    always @(posedge clock)
    begin
        if (!rst_b || pd)
        begin
            rx_hold_reg <= `DSPHY_RST_BYTE;
            rx_full_reg <= `DSPHY_RST_BIT;
        end
        else if (rx_done)
        begin
            rx_hold_reg <= rx_word;                         // [RQ14]
            rx_full_reg <= 1'b1;
        end
        else if (link_tick)
            rx_full_reg <= 1'b0;
    end

    // ------------------------------------------------------------
    // Encoder and port drivers
    // ------------------------------------------------------------
    reg              enc_d_reg;
    reg              enc_s_reg;
    reg              enc_d_next;
    reg              enc_s_next;
    reg  [NPORT-1:0] drv_next;
    reg  [NPORT-1:0] rxp_hot;
    wire             enc_evt;
    wire             enc_bit;

    // Repeating shares the encoder and wins; local transmit words are dropped while rx_active
    assign enc_evt = rx_active ? rx_evt : tx_bit_evt;
    assign enc_bit = rx_active ? rx_d : tx_shift_reg[0];    // [RQ16]

    // Strobe flips only when the data bit repeats
    always @*
    begin
        enc_d_next = enc_d_reg;
        enc_s_next = enc_s_reg;
        rxp_hot    = {{(NPORT-1){1'b0}}, 1'b1} << rx_port;
        if (enc_evt)
        begin
            enc_d_next = enc_bit;                           // [RQ9]
            enc_s_next = enc_s_reg ^ (enc_bit == enc_d_reg); // [RQ18]
        end
        if (pd)
            drv_next = {NPORT{1'b0}};                       // [RQ3]
        else if (rx_active)
            drv_next = port_ok & ~rxp_hot;                  // [RQ11] [RQ16]
        else if (tx_on_reg)
            drv_next = port_ok;                             // [RQ4] [RQ10]
        else
            drv_next = {NPORT{1'b0}};
    end

    // Cable driver and receiver enables, all from flops
    always @(posedge clock)
    begin
        if (!rst_b)
        begin
            enc_d_reg      <= `DSPHY_RST_BIT;
            enc_s_reg      <= `DSPHY_RST_BIT;
            tpa_tx         <= {NPORT{1'b0}};
            tpb_tx         <= {NPORT{1'b0}};
            tpa_tx_oe_b    <= {NPORT{`DSPHY_RST_OE_B}};
            tpb_tx_oe_b    <= {NPORT{`DSPHY_RST_OE_B}};
            rx_enable      <= {NPORT{1'b0}};
            bias_detect_en <= {NPORT{1'b1}};
        end
        else
        begin
            enc_d_reg      <= enc_d_next;
            enc_s_reg      <= enc_s_next;
            tpb_tx         <= {NPORT{enc_d_next}} & drv_next; // [RQ10]
            tpa_tx         <= {NPORT{enc_s_next}} & drv_next;
            tpa_tx_oe_b    <= ~drv_next;                    // [RQ4]
            tpb_tx_oe_b    <= ~drv_next;
            rx_enable      <= (pd || !rx_active) ? {NPORT{1'b0}} :
                              (port_ok & rxp_hot);          // [RQ4] [RQ11]
            bias_detect_en <= {NPORT{1'b1}};                // [RQ3]
        end
    end

    // ------------------------------------------------------------
    // Link-side outputs and isolation coding
    // ------------------------------------------------------------
    reg  [7:0] lvl_data_reg;
    reg        lvl_valid_reg;
    wire [7:0] lvl_data_next;
    wire       lvl_valid_next;

    assign lvl_data_next  = rx_full_reg ? rx_hold_reg : `DSPHY_RST_BYTE;
    assign lvl_valid_next = rx_full_reg;

    // Edge coding gives one pulse per change, so a barrier passes it
    always @(posedge clock)
    begin
        if (!rst_b || pd)
        begin
            lvl_data_reg         <= `DSPHY_RST_BYTE;
            lvl_valid_reg        <= `DSPHY_RST_BIT;
            link_data_lines_out  <= `DSPHY_RST_BYTE;
            link_data_lines_oe_b <= {8{`DSPHY_RST_OE_B}};
            rx_valid             <= `DSPHY_RST_BIT;
            rx_speed_out         <= `DSPHY_SPD_S100;
        end
        else if (link_tick)
        begin
            lvl_data_reg         <= lvl_data_next;          // [RQ15]
            lvl_valid_reg        <= lvl_valid_next;
            rx_speed_out         <= rx_speed;
            link_data_lines_oe_b <= {8{~rx_active}};        // [RQ17]
            if (iso_hi)
            begin
                link_data_lines_out <= lvl_data_next;       // [RQ5]
                rx_valid            <= lvl_valid_next;
            end
            else
            begin
                link_data_lines_out <= lvl_data_next ^ lvl_data_reg; // [RQ6]
                rx_valid            <= lvl_valid_next ^ lvl_valid_reg;
            end
        end
    end

endmodule

// ### tb/dsphy_chk.sv
// Checker for the DS PHY data path: link clock, power down, port drivers.
// Assumes one clock and a synchronous active-low reset on the top module.
module dsphy_chk
#(
    parameter NPORT = 3
)
(
    // Clock, reset and pins
    input wire             clock,
    input wire             rst_b,
    input wire             power_down_input,
    input wire             link_clock_out,
    input wire             pll_run,
    // Link side and arbitration
    input wire [7:0]       link_data_lines_oe_b,
    input wire             rx_valid,
    input wire             rx_active,
    input wire [1:0]       rx_port,
    // Cable ports
    input wire [NPORT-1:0] port_connected,
    input wire [NPORT-1:0] port_disabled,
    input wire [NPORT-1:0] port_suspended,
    input wire [NPORT-1:0] tpa_tx,
    input wire [NPORT-1:0] tpa_tx_oe_b,
    input wire [NPORT-1:0] tpb_tx,
    input wire [NPORT-1:0] tpb_tx_oe_b,
    input wire [NPORT-1:0] rx_enable,
    input wire [NPORT-1:0] bias_detect_en
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);
    // Ports that must stay silent
    wire [NPORT-1:0] off_port = ~port_connected | port_disabled
                                | port_suspended;

    // Pin filter delays power down, so attempts around it are dropped
    a_link_period: assert property (
        disable iff (!rst_b || power_down_input)
        $rose(link_clock_out) |-> ##8 $rose(link_clock_out))
        else $error("link clock period is not eight cycles");
    a_link_high: assert property (
        disable iff (!rst_b || power_down_input)
        $rose(link_clock_out) |-> link_clock_out[*4] ##1 !link_clock_out)
        else $error("link clock high phase is not four cycles");
    a_pd_stops_all: assert property (
        power_down_input[*6] |-> !pll_run && !link_clock_out
        && (&tpa_tx_oe_b) && (&tpb_tx_oe_b))
        else $error("power down left clock or drivers running");
    a_bias_kept_on: assert property (
        &bias_detect_en)
        else $error("bias detector switched off");
    a_off_port_quiet: assert property (
        &((tpa_tx_oe_b & tpb_tx_oe_b & ~rx_enable)
        | ~($past(off_port) & $past(off_port, 2))))
        else $error("unusable port has driver or receiver on");
    a_rx_port_off: assert property (
        rx_active[*3] |-> tpa_tx_oe_b[rx_port] && tpb_tx_oe_b[rx_port])
        else $error("receiving port still drives the cable");
    a_ds_one_change: assert property (
        ~|((tpa_tx ^ $past(tpa_tx)) & (tpb_tx ^ $past(tpb_tx))
        & ~tpb_tx_oe_b & ~$past(tpb_tx_oe_b)))
        else $error("data and strobe changed together");
    a_lines_driven: assert property (
        rx_active[*8] |=> link_data_lines_oe_b == 8'h00)
        else $error("device not driving link lines in receive");
    a_lines_freed: assert property (
        (!rx_active)[*8] |=> link_data_lines_oe_b == 8'hff)
        else $error("device drives link lines outside receive");
    c_tx_start: cover property ($fell(tpb_tx_oe_b[0]));
    c_rx_word: cover property ($rose(rx_valid));
    c_pd_entry: cover property ($fell(pll_run));
endmodule

bind dsphy_datapath dsphy_chk #(.NPORT(NPORT)) chk_u (
    .clock(clock), .rst_b(rst_b), .power_down_input(power_down_input),
    .link_clock_out(link_clock_out), .pll_run(pll_run),
    .link_data_lines_oe_b(link_data_lines_oe_b), .rx_valid(rx_valid),
    .rx_active(rx_active), .rx_port(rx_port),
    .port_connected(port_connected), .port_disabled(port_disabled),
    .port_suspended(port_suspended), .tpa_tx(tpa_tx),
    .tpa_tx_oe_b(tpa_tx_oe_b), .tpb_tx(tpb_tx), .tpb_tx_oe_b(tpb_tx_oe_b),
    .rx_enable(rx_enable), .bias_detect_en(bias_detect_en));

// ### tb/dsphy_link_model.sv
// Link controller model: presents transmit words once per link period.
// Assumes the bench queues words through send and resolves the lines.
module dsphy_link_model
(
    // Clocks and line direction
    input  wire        clock,
    input  wire        link_clock_out,
    input  wire [7:0]  link_data_lines_oe_b,
    // Transmit side toward the device
    output logic [7:0] drv,
    output logic       tx_valid,
    output logic [1:0] tx_speed
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] pend_q[$];
    logic       lck_q;

    initial
    begin
        drv = 8'h00;
        tx_valid = 1'b0;
        tx_speed = 2'h0;
        lck_q = 1'b0;
    end

    task automatic send(input logic [7:0] w, input logic [1:0] s);
        pend_q.push_back({s, w});
    endtask

    // Change just after the link clock rises, so the word stands a period
    always @(negedge clock)
    begin
        lck_q <= link_clock_out;
        if (link_clock_out && !lck_q)
        begin
            if (pend_q.size() > 0 && (&link_data_lines_oe_b))
            begin
                {tx_speed, drv} <= pend_q.pop_front();
                tx_valid <= 1'b1;
            end
            else
            begin
                tx_valid <= 1'b0;
                drv <= ~drv; // Idle lines flip each period, never holding the prior value
            end
        end
    end
endmodule

// ### tb/tb_dsphy_datapath.sv
// Bench for the DS PHY data path: link words out, cable words back in.
// Assumes the link model and the bound checker are compiled before it.
`include "dsphy_regs.vh"
module tb_dsphy_datapath;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clock = 1'b0;
    logic       rst_b = 1'b0;
    logic       pd = 1'b0;
    logic       iso_b = 1'b1;
    logic       rx_act = 1'b0;
    logic [1:0] rx_spd = 2'h0;
    logic [2:0] pconn = 3'h7;
    logic [2:0] pdis = 3'h0;
    logic [2:0] psus = 3'h0;
    logic [2:0] ta_rx = 3'h0;
    logic [2:0] tb_rx = 3'h0;
    logic [1:0] rx_pt = 2'h1;
    wire  [7:0] ldo, ldoe, drv, lin;
    wire  [2:0] ta, taoe, tbb, tboe;
    wire  [1:0] tsp, rxs;
    wire        tv, lck, rxv, pll;
    logic [11:0] txq[$];
    logic [9:0] rxq[$];
    logic [11:0] et;
    logic [9:0] er;
    logic [7:0] acc = 8'h00;
    logic       pa = 1'b0, pb = 1'b0, rv_q = 1'b0, dq = 1'b0, sq = 1'b0;
    int         failures = 0;
    int         cmp_count = 0;
    int         seed = 41;
    int         nb = 0, run = 0, last_run = 0;

    always #5 clock = ~clock;
    assign lin = (ldoe & drv) | (~ldoe & ldo);

    dsphy_datapath #(.NPORT(3)) dut_u (
        .clock(clock), .rst_b(rst_b), .power_down_input(pd),
        .iso_select_b(iso_b), .link_clock_out(lck), .pll_run(pll),
        .link_data_lines_in(lin), .link_data_lines_out(ldo),
        .link_data_lines_oe_b(ldoe), .tx_valid(tv), .tx_speed(tsp),
        .rx_valid(rxv), .rx_speed_out(rxs), .rx_active(rx_act),
        .rx_port(rx_pt), .rx_speed(rx_spd), .port_connected(pconn),
        .port_disabled(pdis), .port_suspended(psus), .tpa_rx(ta_rx),
        .tpb_rx(tb_rx), .tpa_tx(ta), .tpa_tx_oe_b(taoe), .tpb_tx(tbb),
        .tpb_tx_oe_b(tboe), .rx_enable(), .bias_detect_en());
    dsphy_link_model lm_u (.clock(clock), .link_clock_out(lck),
        .link_data_lines_oe_b(ldoe), .drv(drv), .tx_valid(tv),
        .tx_speed(tsp));

    function automatic logic [3:0] wid(input logic [1:0] s);
        wid = (s == `DSPHY_SPD_S100) ? `DSPHY_W_S100 :
              (s == `DSPHY_SPD_S200) ? `DSPHY_W_S200 : `DSPHY_W_S400;
    endfunction
    function automatic logic [7:0] msk(input logic [3:0] n);
        msk = 8'hff >> (4'h8 - n);
    endfunction

    task automatic check(input string what, input logic [7:0] exp,
                         input logic [7:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic final_report;
        $display("Comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Upper lines carry junk that the device must ignore
    task automatic send_tx(input logic [1:0] s);
        logic [7:0] w;
        w = 8'($random(seed));
        lm_u.send(w, s);
        txq.push_back({wid(s), w & msk(wid(s))});
    endtask
    // One bit per link period: the pin filter needs two agreeing samples per bit
    task automatic rx_word(input logic [1:0] s);
        logic [7:0] w;
        w = 8'($random(seed)) & msk(wid(s));
        rxq.push_back({s, w});
        txq.push_back({wid(s), w});
        rx_spd = s;
        for (int i = 0; i < wid(s); i++)
        begin
            sq = (w[i] == dq) ? ~sq : sq;
            dq = w[i];
            ta_rx[rx_pt] = dq;
            tb_rx[rx_pt] = sq;
            repeat (8) @(negedge clock);
        end
        // Speed is copied at each tick, so hold it until the word is out
        repeat (8) @(negedge clock);
    endtask
    task automatic drain;
        for (int n = 0; n < 600 && txq.size() + rxq.size() > 0; n++)
            @(negedge clock);
        check("queues empty", 8'h00, 8'(txq.size() + rxq.size()));
        repeat (24) @(negedge clock);
    endtask

    // Decode port 0 as the far-end receiver would
    always @(negedge clock)
    begin
        if (tboe[0] !== 1'b0)
        begin
            pa = 1'b0;
            pb = 1'b0;
            nb = 0;
        end
        else if ((ta[0] ^ tbb[0]) !== (pa ^ pb))
        begin
            acc[nb] = tbb[0];
            nb++;
            pa = ta[0];
            pb = tbb[0];
            if (txq.size() == 0)
            begin
                check("tx extra", 8'h00, 8'hff);
                nb = 0;
            end
            else if (nb == txq[0][11:8])
            begin
                et = txq.pop_front();
                check("tx word", et[7:0], acc & msk(et[11:8]));
                nb = 0;
            end
        end
    end
    // Take each receive word at the rise of its valid flag
    always @(negedge clock)
    begin
        if (rxv === 1'b1 && rv_q !== 1'b1)
        begin
            if (rxq.size() == 0)
                check("rx extra", 8'h00, 8'hff);
            else
            begin
                er = rxq.pop_front();
                check("rx word", er[7:0], ldo);
                check("rx speed", {6'h00, er[9:8]}, {6'h00, rxs});
            end
        end
        if (rxv === 1'b1)
            run++;
        else if (run > 0)
        begin
            last_run = run;
            run = 0;
        end
        rv_q = rxv;
    end

    initial
    begin
        repeat (20) @(negedge clock);
        rst_b = 1'b1;
        repeat (12) @(negedge clock);
        for (int k = 0; k < 3; k++)
        begin
            pdis[2] = (k == 0);
            psus[2] = (k == 1);
            pconn[2] = (k != 2);
            repeat (3) send_tx(2'(k));
            drain();
        end
        pconn = 3'h7;
        pd = 1'b1;
        repeat (30) @(negedge clock);
        check("pll run", 8'h00, {7'h00, pll});
        pd = 1'b0;
        repeat (20) @(negedge clock);
        send_tx(2'h2);
        drain();
        rx_act = 1'b1;
        repeat (8) @(negedge clock);
        for (int k = 0; k < 3; k++)
            rx_word(2'(k));
        drain();
        check("plain span", 8'h08, 8'(last_run));
        // Move reception to port 2 while idle, then coded outputs
        rx_act = 1'b0;
        iso_b = 1'b0;
        repeat (16) @(negedge clock);
        rx_pt = 2'h2;
        rx_act = 1'b1;
        repeat (8) @(negedge clock);
        rx_word(2'h2);
        drain();
        check("coded span", 8'h10, 8'(last_run));
        rx_act = 1'b0;
        repeat (16) @(negedge clock);
        final_report();
    end
    // The sequence needs under 10 us; allow over ten times that
    initial
    begin
        #100000;
        failures++;
        final_report();
    end
endmodule
